// ===== rtl/cws_option_loader.sv
`timescale 1ns/10ps
`include "cws_params.svh"

module cws_option_loader (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic secured_i,
   input wire logic special_mode_i,
   input wire logic wdog_cause_i,
   input wire logic nv_ack_i,
   input wire logic [7:0] nv_data_i,
   output logic nv_req_o,
   output logic [23:0] nv_addr_o,
   output logic [7:0] opt_o,
   output logic [2:0] rate_o,
   output logic win_o,
   output logic done_o
);
   import cws_pkg::*;

   cws_ld_t q;
   cws_ld_t d;

   // ----------------------------------------------------------------
   // fetch the option byte once after reset release
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      case (q.state)
         cws_ld_req: begin
            d.req = 1'b1;
            d.addr = `CWS_NV_ADDR;
            d.state = cws_ld_wait;
         end
         cws_ld_wait: begin
            if (nv_ack_i) begin
               d.req = 1'b0;
               d.opt = nv_data_i;
               d.rate = ~nv_data_i[2:0];
               d.win = ~nv_data_i[`CWS_OPT_WIN];
               // secured part in special mode starts at the longest rate when the watchdog caused the reset
               if (secured_i && special_mode_i && wdog_cause_i) begin
                  d.rate = `CWS_RATE_LONGEST;
               end
               d.done = 1'b1;
               d.state = cws_ld_done;
            end
         end
         cws_ld_done: begin
            d.req = 1'b0;
         end
         default: begin
            d.state = cws_ld_req;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q.state <= cws_ld_req;
         q.req <= 1'b0;
         q.addr <= 24'h000000;
         q.opt <= `CWS_OPT_RESET;
         q.rate <= `CWS_RATE_RESET;
         q.win <= 1'b0;
         q.done <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign nv_req_o = q.req;
   assign nv_addr_o = q.addr;
   assign opt_o = q.opt;
   assign rate_o = q.rate;
   assign win_o = q.win;
   assign done_o = q.done;

endmodule : cws_option_loader

// ===== rtl/cws_params.svh
`ifndef CWS_PARAMS_SVH
`define CWS_PARAMS_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define CWS_IDX_OPTION 6'h3b
`define CWS_IDX_CONTROL 6'h3c
`define CWS_IDX_IRQ_STAT 6'h3d
`define CWS_IDX_IRQ_MASK 6'h3e
`define CWS_IDX_SERVICE 6'h3f

// ----------------------------------------------------------------
// control register fields and option byte window bit
// ----------------------------------------------------------------
`define CWS_CTL_WIN 7
`define CWS_CTL_WMASK 5
`define CWS_CTL_HALTW 4
`define CWS_CTL_RUNS 3
`define CWS_CTL_RATE_HI 2
`define CWS_CTL_RATE_LO 0
`define CWS_OPT_WIN 3

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define CWS_IRQ_SERVICED 0
`define CWS_IRQ_TIMEOUT 1
`define CWS_IRQ_BADKEY 2
`define CWS_IRQ_EARLY 3

// ----------------------------------------------------------------
// keys, codes, reset values
// ----------------------------------------------------------------
`define CWS_KEY_FIRST 8'h55
`define CWS_KEY_SECOND 8'haa
`define CWS_RATE_OFF 3'h0
`define CWS_RATE_LONGEST 3'h7
`define CWS_NV_ADDR 24'h03ff0e
`define CWS_OPT_RESET 8'hff
`define CWS_RATE_RESET 3'h0

// ----------------------------------------------------------------
// timeout exponents, in reference ticks, per rate code
// ----------------------------------------------------------------
`define CWS_EXP_R1 5'd6
`define CWS_EXP_R2 5'd8
`define CWS_EXP_R3 5'd10
`define CWS_EXP_R4 5'd12
`define CWS_EXP_R5 5'd14
`define CWS_EXP_R6 5'd15
`define CWS_EXP_R7 5'd16

`endif

// ===== rtl/cws_pkg.sv
package cws_pkg;

   // ----------------------------------------------------------------
   // option loader
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      cws_ld_req,
      cws_ld_wait,
      cws_ld_done
   } cws_ld_state_t;

   typedef struct packed {
      cws_ld_state_t state;
      logic req;
      logic [23:0] addr;
      logic [7:0] opt;
      logic [2:0] rate;
      logic win;
      logic done;
   } cws_ld_t;

   // ----------------------------------------------------------------
   // timeout counter
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] cnt;
      logic expired;
      logic window;
   } cws_cnt_t;

   // ----------------------------------------------------------------
   // top level
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ack;
      logic [7:0] dat;
      logic [2:0] rate;
      logic win;
      logic runs;
      logic haltw;
      logic once;
      logic cfg;
      logic key55;
      logic [3:0] stat;
      logic [3:0] mask;
      logic rst_pulse;
      logic fired;
      logic irq;
   } cws_top_t;

endpackage : cws_pkg

// ===== rtl/cws_timeout_counter.sv
`timescale 1ns/10ps
`include "cws_params.svh"

module cws_timeout_counter #(
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic run_i,
   input wire logic clear_i,
   input wire logic [2:0] rate_i,
   output logic expired_o,
   output logic window_o
);
   import cws_pkg::*;

   cws_cnt_t q;
   cws_cnt_t d;
   logic [4:0] exp_w;
   logic [16:0] period;
   logic [CNT_W-1:0] last;
   logic [CNT_W-1:0] thresh;

   // ----------------------------------------------------------------
   // rate decode
   // ----------------------------------------------------------------
   always_comb begin
      case (rate_i)
         3'h1: exp_w = `CWS_EXP_R1;
         3'h2: exp_w = `CWS_EXP_R2;
         3'h3: exp_w = `CWS_EXP_R3;
         3'h4: exp_w = `CWS_EXP_R4;
         3'h5: exp_w = `CWS_EXP_R5;
         3'h6: exp_w = `CWS_EXP_R6;
         3'h7: exp_w = `CWS_EXP_R7;
         default: exp_w = `CWS_EXP_R7;
      endcase
      period = 17'h00001 << exp_w;
      last = CNT_W'(period - 17'h00001);
      // window opens after three quarters of the period
      thresh = CNT_W'(period - (period >> 2));
   end

   // ----------------------------------------------------------------
   // counting on reference ticks
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.expired = 1'b0;
      if (clear_i) begin
         d.cnt = '0;
      end else if (run_i && tick_i) begin
         if (q.cnt == last) begin
            d.expired = 1'b1;
            d.cnt = '0;
         end else begin
            d.cnt = q.cnt + 16'h0001;
         end
      end
      d.window = (d.cnt >= thresh);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired_o = q.expired;
   assign window_o = q.window;

endmodule : cws_timeout_counter

// ===== rtl/cws_top.sv
// Functional notes
// - rate zero: service writes ignored
// - wrong service value resets at once
// - timeout without sequence causes reset
// - normal mode tolerates repeated single keys
// - window mode: early write resets
// - window: 55 repeats, aa restarts
// - counter on reference clock, seven rates
// - run_in_stop keeps counter running
// - halt_in_wait clear keeps counter running
// - secured special start after watchdog cause forces longest rate
// - rate and window loaded after reset
// - initial rate is inverted stored code
// - initial window is inverted stored bit
// - option byte fetched from fixed address
// - rate codes map to power-of-two periods
// - nonzero unmasked rate write restarts period; outside special mode only if it is the first unmasked control write
`timescale 1ns/10ps
`include "cws_params.svh"

module cws_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // ----------------------------------------------------------------
   // timing and operating modes
   // ----------------------------------------------------------------
   input wire logic ref_tick_i,
   input wire logic stop_mode_i,
   input wire logic wait_mode_i,
   input wire logic special_mode_i,
   input wire logic secured_i,
   input wire logic wdog_cause_i,
   // ----------------------------------------------------------------
   // option byte link
   // ----------------------------------------------------------------
   output logic nv_req_o,
   output logic [23:0] nv_addr_o,
   input wire logic nv_ack_i,
   input wire logic [7:0] nv_data_i,
   // ----------------------------------------------------------------
   // reset request and interrupt
   // ----------------------------------------------------------------
   output logic wdog_rst_o,
   output logic irq_o
);
   import cws_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cws_top_t q;
   cws_top_t d;

   // ----------------------------------------------------------------
   // loader and counter links
   // ----------------------------------------------------------------
   logic [7:0] ld_opt;
   logic [2:0] ld_rate;
   logic ld_win;
   logic ld_done;
   logic expired;
   logic window_open;
   logic cnt_run;
   logic cnt_clear;
   logic restart;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic [5:0] idx;
   logic req;
   logic wr;
   logic [7:0] wdat;
   logic [7:0] rdat;
   logic [3:0] ev;
   logic [3:0] w1c;
   logic enabled;
   logic halted_wait;
   logic stop_frozen;

   // ----------------------------------------------------------------
   // write strobes and key decode
   // ----------------------------------------------------------------
   logic wr_service;
   logic wr_control;
   logic wr_stat;
   logic wr_mask;
   logic ctl_unmasked;
   logic ctl_open;
   logic [2:0] ctl_rate;
   logic ctl_rate_on;
   logic svc_live;
   logic key_first;
   logic key_second;
   logic early;
   logic boot_load;
   logic timeout_hit;

   // ----------------------------------------------------------------
   // option byte loader
   // ----------------------------------------------------------------
   cws_option_loader u_loader (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .secured_i(secured_i),
      .special_mode_i(special_mode_i),
      .wdog_cause_i(wdog_cause_i),
      .nv_ack_i(nv_ack_i),
      .nv_data_i(nv_data_i),
      .nv_req_o(nv_req_o),
      .nv_addr_o(nv_addr_o),
      .opt_o(ld_opt),
      .rate_o(ld_rate),
      .win_o(ld_win),
      .done_o(ld_done)
   );

   // ----------------------------------------------------------------
   // timeout counter
   // ----------------------------------------------------------------
   cws_timeout_counter #(
      .CNT_W(16)
   ) u_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(ref_tick_i),
      .run_i(cnt_run),
      .clear_i(cnt_clear),
      .rate_i(q.rate),
      .expired_o(expired),
      .window_o(window_open)
   );

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   always_comb begin
      idx = adr_i[7:2];
      req = cyc_i && stb_i && !q.ack;
      // a write lands on the edge where the master samples ack
      wr = cyc_i && stb_i && we_i && q.ack && sel_i[0];
      wdat = dat_i[7:0];
      enabled = (q.rate != `CWS_RATE_OFF);
      // wait with halt set initialises, stop without run only freezes
      halted_wait = wait_mode_i && q.haltw;
   end

   // ----------------------------------------------------------------
   // write strobes per register
   // ----------------------------------------------------------------
   always_comb begin
      wr_service = wr && (idx == `CWS_IDX_SERVICE);
      wr_control = wr && (idx == `CWS_IDX_CONTROL);
      wr_stat = wr && (idx == `CWS_IDX_IRQ_STAT);
      wr_mask = wr && (idx == `CWS_IDX_IRQ_MASK);
      // a masked control write neither applies nor uses up the single write
      ctl_unmasked = wr_control && !wdat[`CWS_CTL_WMASK];
      // outside special mode only the first unmasked control write counts
      ctl_open = special_mode_i || !q.once;
      ctl_rate = wdat[`CWS_CTL_RATE_HI:`CWS_CTL_RATE_LO];
      ctl_rate_on = (ctl_rate != `CWS_RATE_OFF);
   end

   // ----------------------------------------------------------------
   // service key classification
   // ----------------------------------------------------------------
   always_comb begin
      // keys count only while enabled and before the request has fired
      svc_live = wr_service && enabled && !q.fired;
      key_first = (wdat == `CWS_KEY_FIRST);
      key_second = (wdat == `CWS_KEY_SECOND);
      // in window mode a key before three quarters of the period is early
      early = q.win && !window_open;
   end

   // ----------------------------------------------------------------
   // loader hand-over and expiry
   // ----------------------------------------------------------------
   always_comb begin
      // the option byte is applied once per reset
      boot_load = ld_done && !q.cfg;
      // expiry after the request fired is ignored, so only one pulse leaves
      timeout_hit = enabled && expired && !q.fired;
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      case (idx)
         `CWS_IDX_OPTION: rdat = ld_opt;
         `CWS_IDX_CONTROL: rdat = {q.win, 2'b00, q.haltw, q.runs, q.rate};
         `CWS_IDX_IRQ_STAT: rdat = {4'h0, q.stat};
         `CWS_IDX_IRQ_MASK: rdat = {4'h0, q.mask};
         `CWS_IDX_SERVICE: rdat = 8'h00;
         default: rdat = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // service keys, control writes, events
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      ev = 4'h0;
      w1c = 4'h0;
      restart = 1'b0;
      d.ack = req;
      if (req) begin
         d.dat = rdat;
      end

      // configuration taken once the option byte has arrived
      if (boot_load) begin
         d.cfg = 1'b1;
         d.rate = ld_rate;
         d.win = ld_win;
         restart = 1'b1;
      end

      // service register
      if (svc_live) begin
         if (early) begin
            ev[`CWS_IRQ_EARLY] = 1'b1;
         end else if (key_first) begin
            d.key55 = 1'b1;
         end else if (key_second) begin
            // a lone second key is tolerated but restarts nothing
            if (q.key55) begin
               restart = 1'b1;
            end
         end else begin
            ev[`CWS_IRQ_BADKEY] = 1'b1;
         end
      end

      // control register, write once outside special mode
      if (ctl_unmasked) begin
         if (ctl_open) begin
            d.once = 1'b1;
            d.runs = wdat[`CWS_CTL_RUNS];
            d.haltw = wdat[`CWS_CTL_HALTW];
            if (special_mode_i) begin
               d.win = wdat[`CWS_CTL_WIN];
            end else if (wdat[`CWS_CTL_WIN]) begin
               d.win = 1'b1;
            end
            if (ctl_rate_on) begin
               d.rate = ctl_rate;
               restart = 1'b1;
            end
         end
      end

      // interrupt mask and clear
      if (wr_mask) begin
         d.mask = wdat[3:0];
      end
      if (wr_stat) begin
         w1c = wdat[3:0];
      end

      if (timeout_hit) begin
         ev[`CWS_IRQ_TIMEOUT] = 1'b1;
      end
      if (restart) begin
         d.key55 = 1'b0;
         ev[`CWS_IRQ_SERVICED] = enabled;
      end

      // one request pulse; the block stays quiet until the system resets it
      d.rst_pulse = 1'b0;
      if (|ev[`CWS_IRQ_EARLY:`CWS_IRQ_TIMEOUT] && !q.fired) begin
         d.rst_pulse = 1'b1;
         d.fired = 1'b1;
      end

      // set wins over a same-cycle clear
      d.stat = (q.stat & ~w1c) | ev;
      d.irq = |(d.stat & d.mask);
   end

   // ----------------------------------------------------------------
   // counter steering
   // ----------------------------------------------------------------
   always_comb begin
      // a frozen counter keeps its count, a cleared one starts over
      stop_frozen = stop_mode_i && !q.runs;
      cnt_run = enabled && !q.fired && !halted_wait;
      if (stop_frozen) begin
         cnt_run = 1'b0;
      end
      cnt_clear = restart || halted_wait || !enabled;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q.ack <= 1'b0;
         q.dat <= 8'h00;
         q.rate <= `CWS_RATE_RESET;
         q.win <= 1'b0;
         q.runs <= 1'b0;
         q.haltw <= 1'b0;
         q.once <= 1'b0;
         q.cfg <= 1'b0;
         q.key55 <= 1'b0;
         q.stat <= 4'h0;
         q.mask <= 4'h0;
         q.rst_pulse <= 1'b0;
         q.fired <= 1'b0;
         q.irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from registers
   // ----------------------------------------------------------------
   assign ack_o = q.ack;
   assign dat_o = {24'h000000, q.dat};
   assign wdog_rst_o = q.rst_pulse;
   assign irq_o = q.irq;

endmodule : cws_top

// ===== test/cws_top_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker for the watchdog service block
// ----------------------------------------------------------------
module cws_top_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic nv_req_o,
   input wire logic [23:0] nv_addr_o,
   input wire logic nv_ack_i,
   input wire logic wdog_rst_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_svc_read;
      s_req and (!we_i && adr_i[7:2] == 6'h3f);
   endsequence
   sequence s_nv_take;
      nv_req_o && nv_ack_i;
   endsequence

   bus_answer_a: assert property (s_req |=> ack_o)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   svc_read_a: assert property (s_svc_read ##1 ack_o |-> dat_o == 32'h0)
      else $error("service register did not read zero");
   nv_addr_a: assert property (nv_req_o |-> nv_addr_o == 24'h03ff0e)
      else $error("option byte fetched from wrong address");
   nv_drop_a: assert property (s_nv_take |=> !nv_req_o)
      else $error("option request held after answer");
   no_early_rst_a: assert property (nv_req_o |-> !wdog_rst_o)
      else $error("watchdog reset before option byte loaded");
   single_pulse_a: assert property (wdog_rst_o |=> !wdog_rst_o [*8])
      else $error("watchdog reset request not a single pulse");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> !wdog_rst_o && !irq_o && !ack_o)
      else $error("outputs active after reset edge");
endmodule : cws_top_checker

bind cws_top cws_top_checker u_cws_top_checker (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
   .ack_o(ack_o), .nv_req_o(nv_req_o), .nv_addr_o(nv_addr_o), .nv_ack_i(nv_ack_i),
   .wdog_rst_o(wdog_rst_o), .irq_o(irq_o));

// ===== test/tb_cws_top.sv
`timescale 1ns/10ps
module tb_cws_top;
   typedef struct {logic [7:0] k1; logic [7:0] k2; logic [31:0] rst;} cws_row_t;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ref_tick_i = 1;
   logic stop_mode_i = 0, wait_mode_i = 0, special_mode_i = 0, secured_i = 0;
   logic wdog_cause_i = 0, nv_ack_i = 0, ack_o, nv_req_o, wdog_rst_o, irq_o;
   logic [7:0] adr_i = 0, nv_data_i = 0, q;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o;
   logic [23:0] nv_addr_o;
   int n_mismatch = 0, compares = 0, n_rst = 0, cycles = 0;
   cws_row_t rows [6] = '{'{8'h55, 8'h55, 0}, '{8'haa, 8'haa, 0}, '{8'h55, 8'haa, 0},
      '{8'h55, 8'h00, 1}, '{8'hff, 8'h55, 1}, '{8'haa, 8'h5a, 1}};

   cws_top u_cws_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .ref_tick_i(ref_tick_i), .stop_mode_i(stop_mode_i),
      .wait_mode_i(wait_mode_i), .special_mode_i(special_mode_i), .secured_i(secured_i),
      .wdog_cause_i(wdog_cause_i), .nv_req_o(nv_req_o), .nv_addr_o(nv_addr_o),
      .nv_ack_i(nv_ack_i), .nv_data_i(nv_data_i), .wdog_rst_o(wdog_rst_o), .irq_o(irq_o));

   // ----------------------------------------------------------------
   // clock, reset-request counter, hang guard
   // ----------------------------------------------------------------
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (wdog_rst_o === 1'b1) n_rst++;
      // whole run is about eleven hundred cycles
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task summarize();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      sel_i <= 4'h1;
      // no local limit: only the bench's cycle ceiling ends the wait
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb

   task svc();
      wb(1'b1, 8'hfc, 8'h55);
      wb(1'b1, 8'hfc, 8'haa);
   endtask : svc

   task do_reset(input logic [7:0] nv);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      chk("quiet_in_reset", 0, {irq_o, wdog_rst_o, ack_o});
      rst_i <= 1'b0;
      do begin
         @(posedge clk_i);
      end while (nv_req_o !== 1'b1);
      chk("nv_addr", 32'h0003ff0e, {8'h0, nv_addr_o});
      nv_ack_i <= 1'b1;
      nv_data_i <= nv;
      @(posedge clk_i);
      nv_ack_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      n_rst = 0;
   endtask : do_reset

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset(8'hfe);
      wb(1'b0, 8'hec, 8'h0);
      chk("option", 8'hfe, q);
      wb(1'b0, 8'hf0, 8'h0);
      chk("control", 8'h01, q);
      wb(1'b0, 8'hfc, 8'h0);
      chk("service_read", 0, q);
      wb(1'b0, 8'h00, 8'h0);
      chk("unmapped", 0, q);
      $display("test reset done");
      foreach (rows[i]) begin
         do_reset(8'hfe);
         wb(1'b1, 8'hfc, rows[i].k1);
         wb(1'b1, 8'hfc, rows[i].k2);
         repeat (3) @(posedge clk_i);
         chk("key_reset", rows[i].rst, n_rst);
      end
      $display("test key table done");
      do_reset(8'hfe);
      wb(1'b1, 8'hf8, 8'h01);
      repeat (8) begin
         repeat (20) @(posedge clk_i);
         svc();
      end
      chk("serviced_no_reset", 0, n_rst);
      chk("irq_serviced", 1, irq_o);
      wb(1'b1, 8'hf4, 8'h0f);
      repeat (2) @(posedge clk_i);
      chk("irq_cleared", 0, irq_o);
      svc();
      // clear the serviced bit so only the masked timeout bit can be pending
      wb(1'b1, 8'hf4, 8'h0f);
      repeat (52) @(posedge clk_i);
      chk("before_timeout", 0, n_rst);
      repeat (20) @(posedge clk_i);
      chk("timeout_reset", 1, n_rst);
      chk("irq_masked", 0, irq_o);
      wb(1'b0, 8'hf4, 8'h0);
      chk("timeout_stat", 8'h02, q);
      $display("test service and timeout done");
      do_reset(8'hff);
      wb(1'b1, 8'hfc, 8'h00);
      repeat (100) @(posedge clk_i);
      chk("disabled_ignores", 0, n_rst);
      // masked control write must neither apply nor use up the single write
      wb(1'b1, 8'hf0, 8'h21);
      wb(1'b0, 8'hf0, 8'h0);
      chk("masked_write", 8'h00, q);
      wb(1'b1, 8'hf0, 8'h01);
      wb(1'b0, 8'hf0, 8'h0);
      chk("rate_write", 8'h01, q);
      stop_mode_i <= 1'b1;
      repeat (200) @(posedge clk_i);
      chk("stop_freezes", 0, n_rst);
      stop_mode_i <= 1'b0;
      wait_mode_i <= 1'b1;
      repeat (80) @(posedge clk_i);
      chk("wait_runs", 1, n_rst);
      wait_mode_i <= 1'b0;
      $display("test enable and low power done");
      do_reset(8'hf6);
      wb(1'b0, 8'hf0, 8'h0);
      chk("window_boot", 8'h81, q);
      wb(1'b1, 8'hfc, 8'h55);
      repeat (3) @(posedge clk_i);
      chk("early_write", 1, n_rst);
      do_reset(8'hf6);
      repeat (50) @(posedge clk_i);
      svc();
      repeat (3) @(posedge clk_i);
      chk("window_service", 0, n_rst);
      wb(1'b1, 8'hfc, 8'h55);
      repeat (3) @(posedge clk_i);
      chk("write_after_restart", 1, n_rst);
      $display("test window done");
      secured_i <= 1'b1;
      special_mode_i <= 1'b1;
      wdog_cause_i <= 1'b1;
      do_reset(8'hfe);
      wb(1'b0, 8'hf0, 8'h0);
      chk("secured_rate", 8'h07, q);
      $display("test secured start done");
      summarize();
   end
endmodule : tb_cws_top
